// *** rtl/cross_trigger_arm_matrix.sv ***
// cross trigger routing matrix: two internal lines, analyzers, break, trigger ports
// Notes on behaviour
// - execute-start option begins the current trace when the bus execute line falls
// - execute is active low; an enabled analyzer abandons its run and restarts
// - bus and coaxial triggers are active low, same role, both directions
// - two internal lines, each with its own route word
// - an analyzer routed as source asserts the line on its trigger
// - break routed as receiver requests the monitor while the line stands
// - with both analyzers as source, the first to trigger takes the line
// - a port routed as receiver shows its trigger while the line stands
// - a port routed as source asserts the line while its input is active and we are not driving that port
// - analyzer is armed always unless an arming source is selected
// - no trace capture before the analyzer is armed
// - analyzer routed as receiver is armed when the line asserts
// - arm term usable as qualifier, except by the external analyzer in timing mode; as trigger qualifier it triggers at arm
// - timing mode with arming source starts acquisition only at the arm
// - either analyzer's trigger may arm the other through a line
// - ports may drive, receive or both; received triggers may break
// - shared line into break fires on analyzer or outside trigger, either
// - analyzer drops the line that caused its break; fed ports drop too
// - trigger on a non-break line stays until halt or next trace
`include "xtrig_defines.svh"
module cross_trigger_arm_matrix (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // register port
   input  wire logic [`XT_AW-1:0] reg_addr,
   input  wire logic [`XT_DW-1:0] reg_wdata,
   input  wire logic              reg_we,
   input  wire logic              reg_re,
   output logic      [`XT_DW-1:0] reg_rdata,
   // internal emulation analyzer
   input  wire logic              int_cond,
   output logic                   int_armed,
   output logic                   int_acquire,
   output logic                   int_running,
   output logic                   int_trig,
   // external analyzer
   input  wire logic              ext_cond,
   output logic                   ext_armed,
   output logic                   ext_acquire,
   output logic                   ext_running,
   output logic                   ext_trig,
   // emulator break
   output logic                   break_req,
   // coordinated measurement bus
   input  wire logic              coordinated_measurement_bus_exec_n,
   input  wire logic              coordinated_measurement_bus_trig_in_n,
   output logic                   coordinated_measurement_bus_trig_out_n,
   output logic                   coordinated_measurement_bus_trig_oe_n,
   // coaxial trigger port
   input  wire logic              coaxial_trigger_port_in_n,
   output logic                   coaxial_trigger_port_out_n,
   output logic                   coaxial_trigger_port_oe_n
);
   // control and read state
   logic [`XT_CTRL_W-1:0] ctrl_q;
   logic [`XT_DW-1:0]     rdata_q;
   logic                  exec_q;
   logic                  break_q;
   logic                  bus_drv_q;
   logic                  coax_drv_q;

   // per-line results
   logic [1:0] line_w;
   logic [1:0] arm_int_w;
   logic [1:0] arm_ext_w;
   logic [1:0] brk_w;
   logic [1:0] to_bus_w;
   logic [1:0] to_coax_w;
   logic [1:0] owner_w [2];
   xtrig_pkg::route_cfg_t cfg_rd [2];
   xtrig_pkg::route_cfg_t live_w [2];

   // address decode
   wire sel_a    = reg_addr == `XT_OFS_LINE_A;
   wire sel_b    = reg_addr == `XT_OFS_LINE_B;
   wire sel_ctrl = reg_addr == `XT_OFS_CTRL;
   wire sel_stat = reg_addr == `XT_OFS_STAT;
   wire wr_ctrl  = reg_we && sel_ctrl;

   // execute is active low; a falling edge is one execute event
   wire exec_fall = exec_q && !coordinated_measurement_bus_exec_n;

   // starts come from software or from an enabled execute event
   wire go_int   = (wr_ctrl && reg_wdata[`XT_C_GO_INT])
                 || (exec_fall && ctrl_q[`XT_C_EXEC_INT]);
   wire go_ext   = (wr_ctrl && reg_wdata[`XT_C_GO_EXT])
                 || (exec_fall && ctrl_q[`XT_C_EXEC_EXT]);
   wire halt_int = wr_ctrl && reg_wdata[`XT_C_HALT_INT];
   wire halt_ext = wr_ctrl && reg_wdata[`XT_C_HALT_EXT];
   wire restart  = go_int || go_ext;
   wire idle     = !int_running && !ext_running;

   // incoming port triggers, active low; our own drive is masked out, which
   // stops a two-way port latching its own line, at the cost of not seeing
   // an outside trigger while we hold the wire low
   wire bus_in  = !coordinated_measurement_bus_trig_in_n
                  && !bus_drv_q;
   wire coax_in = !coaxial_trigger_port_in_n && !coax_drv_q;

   // arming inputs collected across both lines
   wire int_arm_sel = live_w[0][`XT_B_INT_RCV] || live_w[1][`XT_B_INT_RCV];
   wire ext_arm_sel = live_w[0][`XT_B_EXT_RCV] || live_w[1][`XT_B_EXT_RCV];
   wire int_arm_in  = |arm_int_w;
   wire ext_arm_in  = |arm_ext_w;
   wire timing      = ctrl_q[`XT_C_TIMING];
   // a timing analyzer has no state qualifiers, so the arm term is unused there
   wire ext_atrg    = ctrl_q[`XT_C_ATRG_EXT] && !timing;

   // drive requests toward the break and the ports
   wire brk_any  = |brk_w;
   wire bus_drv  = |to_bus_w;
   wire coax_drv = |to_coax_w;

   // status word seen by software
   wire [`XT_DW-1:0] stat_w = `XT_DW'({owner_w[1], owner_w[0], break_q, line_w,
                                       ext_trig, int_trig, ext_running, int_running,
                                       ext_armed, int_armed});

   // read selection; unmapped addresses read as zero
   wire [`XT_DW-1:0] rd_mux = sel_a    ? `XT_DW'(cfg_rd[0])
                            : sel_b    ? `XT_DW'(cfg_rd[1])
                            : sel_ctrl ? `XT_DW'(ctrl_q)
                            : sel_stat ? stat_w
                            : `XT_DW'(0);

   // internal emulation analyzer
   analyzer_arm u_int (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .start       (go_int),
      .halt        (halt_int),
      .trig_on_arm (ctrl_q[`XT_C_ATRG_INT]),
      .arm_sel     (int_arm_sel),
      .arm_in      (int_arm_in),
      .cond        (int_cond),
      .armed       (int_armed),
      .acquire     (int_acquire),
      .running     (int_running),
      .trig        (int_trig)
   );

   // external analyzer, state or timing
   analyzer_arm u_ext (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .start       (go_ext),
      .halt        (halt_ext),
      .trig_on_arm (ext_atrg),
      .arm_sel     (ext_arm_sel),
      .arm_in      (ext_arm_in),
      .cond        (ext_cond),
      .armed       (ext_armed),
      .acquire     (ext_acquire),
      .running     (ext_running),
      .trig        (ext_trig)
   );

   // one route word, live copy and router per internal line
   for (genvar g = 0; g < 2; g++) begin : lines
      xtrig_pkg::route_cfg_t cfg_q;
      xtrig_pkg::route_cfg_t live_q;
      wire wr_cfg = reg_we && (g == 0 ? sel_a : sel_b);

      // software copy of the route word
      always_ff @(posedge clock) begin
         if (sys_rst) cfg_q <= `XT_CFG_RST;
         else if (wr_cfg) cfg_q <= reg_wdata[`XT_CFG_W-1:0] & `XT_CFG_MASK;
      end

      // routes load while both analyzers are idle or at any start, even one made while the other analyzer is running
      always_ff @(posedge clock) begin
         if (sys_rst) live_q <= `XT_CFG_RST;
         else if (restart || idle) live_q <= cfg_q;
      end

      assign cfg_rd[g] = cfg_q;
      assign live_w[g] = live_q;

      line_route u_route (
         .clock    (clock),
         .sys_rst  (sys_rst),
         .cfg      (live_q),
         .restart  (restart),
         .int_trig (int_trig),
         .ext_trig (ext_trig),
         .bus_in   (bus_in),
         .coax_in  (coax_in),
         .line     (line_w[g]),
         .arm_int  (arm_int_w[g]),
         .arm_ext  (arm_ext_w[g]),
         .brk      (brk_w[g]),
         .to_bus   (to_bus_w[g]),
         .to_coax  (to_coax_w[g]),
         .owner    (owner_w[g])
      );
   end

   // named copies of the two internal lines
   wire cross_trigger_line_a = line_w[0];
   wire cross_trigger_line_b = line_w[1];

   // stored control bits; command bits are not kept
   always_ff @(posedge clock) begin
      if (sys_rst) ctrl_q <= `XT_CTRL_RST;
      else if (wr_ctrl) ctrl_q <= reg_wdata[`XT_CTRL_W-1:0];
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clock) begin
      if (sys_rst) rdata_q <= `XT_DW'(0);
      else if (reg_re) rdata_q <= rd_mux;
      else rdata_q <= `XT_DW'(0);
   end

   // previous execute level, idle high
   always_ff @(posedge clock) begin
      if (sys_rst) exec_q <= 1'b1;
      else exec_q <= coordinated_measurement_bus_exec_n;
   end

   // break request follows any line routed into the break
   always_ff @(posedge clock) begin
      if (sys_rst) break_q <= 1'b0;
      else break_q <= brk_any;
   end

   // open-drain port drives, held in flops to keep the wire loop-free
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bus_drv_q  <= 1'b0;
         coax_drv_q <= 1'b0;
      end else begin
         bus_drv_q  <= bus_drv;
         coax_drv_q <= coax_drv;
      end
   end

   // outputs; an active trigger pulls the wire low, enable low while driving
   assign reg_rdata                              = rdata_q;
   assign break_req                              = break_q;
   assign coordinated_measurement_bus_trig_out_n = !bus_drv_q;
   assign coordinated_measurement_bus_trig_oe_n  = !bus_drv_q;
   assign coaxial_trigger_port_out_n             = !coax_drv_q;
   assign coaxial_trigger_port_oe_n              = !coax_drv_q;

   // execute start sequence: enabled fall, no halt beside it
   sequence exec_event_s;
      exec_fall && ctrl_q[`XT_C_EXEC_INT] && !halt_int;
   endsequence

   exec_start_a: assert property (@(posedge clock) disable iff (sys_rst)
      exec_event_s |=> int_running ##0 !int_trig)
      else $error("execute did not start the internal trace");
   exec_ext_a: assert property (@(posedge clock) disable iff (sys_rst)
      exec_fall && ctrl_q[`XT_C_EXEC_EXT] && !halt_ext |=> ext_running && !ext_trig)
      else $error("execute did not restart the external analyzer");
   break_route_a: assert property (@(posedge clock) disable iff (sys_rst)
      brk_any |=> break_req)
      else $error("routed line did not request a break");
   port_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      cross_trigger_line_b && live_w[1][`XT_B_BUS_RCV]
      |=> !coordinated_measurement_bus_trig_oe_n)
      else $error("bus trigger not driven from its line");
   coax_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      cross_trigger_line_a && live_w[0][`XT_B_COAX_RCV]
      |=> !coaxial_trigger_port_oe_n)
      else $error("coaxial trigger not driven from its line");
   cross_arm_a: assert property (@(posedge clock) disable iff (sys_rst)
      int_trig && live_w[0][`XT_B_INT_SRC] && live_w[0][`XT_B_EXT_RCV]
      && !restart && !(live_w[0][`XT_B_BRK_RCV]) |=> ext_armed)
      else $error("internal trigger did not arm the external analyzer");
endmodule

// *** rtl/xtrig_defines.svh ***
// register map, field positions and reset values of the cross trigger matrix
`ifndef XTRIG_DEFINES_SVH
`define XTRIG_DEFINES_SVH

// register port widths
`define XT_AW          8
`define XT_DW          32

// register offsets
`define XT_OFS_LINE_A  8'h00
`define XT_OFS_LINE_B  8'h04
`define XT_OFS_CTRL    8'h08
`define XT_OFS_STAT    8'h0c

// route word: per endpoint, low bit drives the line, high bit receives it; break has only its receive bit, bit 4 is masked
`define XT_CFG_W       10
`define XT_CFG_MASK    10'h3ef
`define XT_CFG_RST     10'h000
`define XT_B_INT_SRC   0
`define XT_B_INT_RCV   1
`define XT_B_EXT_SRC   2
`define XT_B_EXT_RCV   3
`define XT_B_BRK_RCV   5
`define XT_B_BUS_SRC   6
`define XT_B_BUS_RCV   7
`define XT_B_COAX_SRC  8
`define XT_B_COAX_RCV  9

// control word: stored bits, then self-clearing command bits
`define XT_CTRL_W      5
`define XT_CTRL_RST    5'h00
`define XT_C_EXEC_INT  0
`define XT_C_EXEC_EXT  1
`define XT_C_TIMING    2
`define XT_C_ATRG_INT  3
`define XT_C_ATRG_EXT  4
`define XT_C_GO_INT    8
`define XT_C_GO_EXT    9
`define XT_C_HALT_INT  10
`define XT_C_HALT_EXT  11

`endif

// *** rtl/xtrig_pkg.sv ***
// types shared by the cross trigger matrix
`include "xtrig_defines.svh"
package xtrig_pkg;
   // measurement state of one analyzer
   typedef enum logic [2:0] {
      AN_IDLE = 3'b001,
      AN_RUN  = 3'b010,
      AN_TRIG = 3'b100
   } an_state_t;
   // route word of one internal line
   typedef logic [`XT_CFG_W-1:0] route_cfg_t;
endpackage

// *** rtl/analyzer_arm.sv ***
// arming and trigger sequencing of one analyzer
`include "xtrig_defines.svh"
module analyzer_arm (
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // measurement control
   input  wire logic start,
   input  wire logic halt,
   input  wire logic trig_on_arm,
   // arming
   input  wire logic arm_sel,
   input  wire logic arm_in,
   // pattern logic
   input  wire logic cond,
   // state
   output logic      armed,
   output logic      acquire,
   output logic      running,
   output logic      trig
);
   xtrig_pkg::an_state_t state_q;
   xtrig_pkg::an_state_t state_d;
   logic                 arm_q;
   wire                  fire;

   // no arming source means armed at all times
   assign armed   = !arm_sel || arm_q;
   assign running = state_q != xtrig_pkg::AN_IDLE;
   // capture waits for the arm; timing acquisition thus starts at the arm
   assign acquire = running && armed;
   assign trig    = state_q == xtrig_pkg::AN_TRIG;
   // arm term may stand as the trigger qualifier itself
   assign fire    = armed && (cond || trig_on_arm);

   // a start restarts the measurement from any state; a halt in the same cycle wins except in idle
   always_comb begin
      state_d = state_q;
      case (state_q)
         xtrig_pkg::AN_IDLE: begin
            if (start) state_d = xtrig_pkg::AN_RUN;
         end
         xtrig_pkg::AN_RUN: begin
            if (halt) state_d = xtrig_pkg::AN_IDLE;
            else if (!start && fire) state_d = xtrig_pkg::AN_TRIG;
         end
         xtrig_pkg::AN_TRIG: begin
            // trigger stays up until halt or the next start
            if (halt) state_d = xtrig_pkg::AN_IDLE;
            else if (start) state_d = xtrig_pkg::AN_RUN;
         end
         default: state_d = xtrig_pkg::AN_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) state_q <= xtrig_pkg::AN_IDLE;
      else state_q <= state_d;
   end

   // arm is set over a restart so a coincident arm is not lost
   always_ff @(posedge clock) begin
      if (sys_rst) arm_q <= 1'b0;
      else if (arm_in) arm_q <= 1'b1;
      else if (start) arm_q <= 1'b0;
   end

   arm_on_line_a: assert property (@(posedge clock) disable iff (sys_rst)
      arm_in |=> armed)
      else $error("line assertion did not arm the analyzer");
   unarmed_no_trig_a: assert property (@(posedge clock) disable iff (sys_rst)
      (state_q == xtrig_pkg::AN_RUN) && !armed && !arm_in |=> !trig)
      else $error("analyzer triggered while unarmed");
   arm_trigger_a: assert property (@(posedge clock) disable iff (sys_rst)
      (state_q == xtrig_pkg::AN_RUN) && armed && trig_on_arm && !halt && !start
      |=> trig)
      else $error("arm qualifier did not trigger");
   trig_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
      trig && !halt && !start |=> trig)
      else $error("trigger dropped before halt or restart");
endmodule

// *** rtl/line_route.sv ***
// sources, receivers and break release of one internal cross trigger line
`include "xtrig_defines.svh"
module line_route (
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   // live route word and restart
   input  wire xtrig_pkg::route_cfg_t  cfg,
   input  wire logic                   restart,
   // sources
   input  wire logic                   int_trig,
   input  wire logic                   ext_trig,
   input  wire logic                   bus_in,
   input  wire logic                   coax_in,
   // receivers
   output logic                        line,
   output logic                        arm_int,
   output logic                        arm_ext,
   output logic                        brk,
   output logic                        to_bus,
   output logic                        to_coax,
   // first analyzer to drive: bit0 internal, bit1 external
   output logic [1:0]                  owner
);
   logic [1:0] owner_q;
   logic       kill_q;
   wire        int_d = cfg[`XT_B_INT_SRC] && int_trig;
   wire        ext_d = cfg[`XT_B_EXT_SRC] && ext_trig;
   wire        ana   = (int_d || ext_d) && !kill_q;
   wire        port  = (cfg[`XT_B_BUS_SRC] && bus_in) || (cfg[`XT_B_COAX_SRC] && coax_in);

   // line is the or of every enabled source; analyzer sources are masked once they have broken through it
   assign line    = ana || port;
   assign arm_int = cfg[`XT_B_INT_RCV] && line;
   assign arm_ext = cfg[`XT_B_EXT_RCV] && line;
   assign brk     = cfg[`XT_B_BRK_RCV] && line;
   assign to_bus  = cfg[`XT_B_BUS_RCV] && line;
   assign to_coax = cfg[`XT_B_COAX_RCV] && line;
   assign owner   = owner_q;

   // first analyzer to reach its trigger takes the line; internal wins a tie
   always_ff @(posedge clock) begin
      if (sys_rst || restart) owner_q <= 2'h0;
      else if (owner_q == 2'h0 && int_d) owner_q <= 2'h1;
      else if (owner_q == 2'h0 && ext_d) owner_q <= 2'h2;
   end

   // analyzer releases a line once it has broken the emulator through it
   always_ff @(posedge clock) begin
      if (sys_rst || restart) kill_q <= 1'b0;
      else if (ana && cfg[`XT_B_BRK_RCV]) kill_q <= 1'b1;
   end

   port_in_a: assert property (@(posedge clock) disable iff (sys_rst)
      cfg[`XT_B_COAX_SRC] && coax_in |-> line)
      else $error("incoming coaxial trigger did not reach the line");
   first_wins_a: assert property (@(posedge clock) disable iff (sys_rst)
      owner_q != 2'h0 && !restart |=> $stable(owner_q))
      else $error("line ownership changed during a measurement");
   break_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
      ana && cfg[`XT_B_BRK_RCV] && !restart ##1 !restart |-> !ana)
      else $error("analyzer kept driving the line after the break");
endmodule

// *** bench/trigger_bus_partner.sv ***
// far side of the trigger ports: other instruments on the bus and coaxial wire
module trigger_bus_partner (
   // commands from the bench
   input  wire logic pull_bus,
   input  wire logic pull_coax,
   input  wire logic exec_req,
   // device side of the open-drain ports
   input  wire logic bus_out_n,
   input  wire logic bus_oe_n,
   input  wire logic coax_out_n,
   input  wire logic coax_oe_n,
   // resolved wire levels
   output logic      bus_level_n,
   output logic      coax_level_n,
   output logic      exec_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // wired-and with a pull-up: a released wire goes high, never keeps a stale low
   assign bus_level_n  = (bus_oe_n | bus_out_n) & ~pull_bus;
   assign coax_level_n = (coax_oe_n | coax_out_n) & ~pull_coax;
   // execute is active low and idles high between requests
   assign exec_n       = ~exec_req;
endmodule

// *** bench/cross_trigger_arm_matrix_bench.sv ***
// self-checking bench for the cross trigger routing matrix
`include "xtrig_defines.svh"
module cross_trigger_arm_matrix_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clock;
   logic              sys_rst;
   logic [`XT_AW-1:0] reg_addr;
   logic [`XT_DW-1:0] reg_wdata;
   logic              reg_we;
   logic              reg_re;
   logic [`XT_DW-1:0] reg_rdata;
   logic              int_cond;
   logic              ext_cond;
   logic              int_armed;
   logic              int_acquire;
   logic              int_running;
   logic              int_trig;
   logic              ext_armed;
   logic              ext_acquire;
   logic              ext_running;
   logic              ext_trig;
   logic              break_req;
   logic              bus_exec_n;
   logic              bus_level_n;
   logic              bus_out_n;
   logic              bus_oe_n;
   logic              coax_level_n;
   logic              coax_out_n;
   logic              coax_oe_n;
   logic              pull_bus;
   logic              pull_coax;
   logic              exec_req;
   logic [31:0]       d;
   int                fail_count;
   int                check_count;

   // 250 MHz system clock
   always #2 clock = ~clock;

   cross_trigger_arm_matrix cross_trigger_arm_matrix_i (
      .clock                                  (clock),
      .sys_rst                                (sys_rst),
      .reg_addr                               (reg_addr),
      .reg_wdata                              (reg_wdata),
      .reg_we                                 (reg_we),
      .reg_re                                 (reg_re),
      .reg_rdata                              (reg_rdata),
      .int_cond                               (int_cond),
      .int_armed                              (int_armed),
      .int_acquire                            (int_acquire),
      .int_running                            (int_running),
      .int_trig                               (int_trig),
      .ext_cond                               (ext_cond),
      .ext_armed                              (ext_armed),
      .ext_acquire                            (ext_acquire),
      .ext_running                            (ext_running),
      .ext_trig                               (ext_trig),
      .break_req                              (break_req),
      .coordinated_measurement_bus_exec_n     (bus_exec_n),
      .coordinated_measurement_bus_trig_in_n  (bus_level_n),
      .coordinated_measurement_bus_trig_out_n (bus_out_n),
      .coordinated_measurement_bus_trig_oe_n  (bus_oe_n),
      .coaxial_trigger_port_in_n              (coax_level_n),
      .coaxial_trigger_port_out_n             (coax_out_n),
      .coaxial_trigger_port_oe_n              (coax_oe_n)
   );

   trigger_bus_partner trigger_bus_partner_i (
      .pull_bus     (pull_bus),
      .pull_coax    (pull_coax),
      .exec_req     (exec_req),
      .bus_out_n    (bus_out_n),
      .bus_oe_n     (bus_oe_n),
      .coax_out_n   (coax_out_n),
      .coax_oe_n    (coax_oe_n),
      .bus_level_n  (bus_level_n),
      .coax_level_n (coax_level_n),
      .exec_n       (bus_exec_n)
   );

   // one compare, counted; a mismatch is reported at once
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // single-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_we    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so take it there
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_re   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(name, exp, d);
   endtask

   // poll one status bit under a bound; running out is a mismatch
   task automatic wait_st(input string name, input int idx, input logic v);
      int n;
      n = 0;
      rd(`XT_OFS_STAT);
      while (d[idx] !== v && n < 30) begin
         rd(`XT_OFS_STAT);
         n++;
      end
      chk(name, {31'h0, v}, {31'h0, d[idx]});
   endtask

   // a released break stands for one cycle only, too short for bus polling
   task automatic wait_brk(input string name, input logic v);
      int n;
      n = 0;
      while (break_req !== v && n < 30) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(name, {31'h0, v}, {31'h0, break_req});
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      clock = 1'b0; sys_rst = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0;
      reg_we = 1'b0; reg_re = 1'b0; int_cond = 1'b0; ext_cond = 1'b0;
      pull_bus = 1'b0; pull_coax = 1'b0; exec_req = 1'b0;
      fail_count = 0; check_count = 0;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      // reset values, unmapped place, route word mask
      rd_chk("status_rst", `XT_OFS_STAT, 32'h0000_0003);
      rd_chk("route_a_rst", `XT_OFS_LINE_A, 32'h0);
      rd_chk("unmapped", 8'h10, 32'h0);
      wr(`XT_OFS_LINE_A, 32'hffff_ffff);
      rd_chk("route_a_mask", `XT_OFS_LINE_A, 32'h0000_03ef);
      rd_chk("route_b_apart", `XT_OFS_LINE_B, 32'h0);
      // line a breaks, line b drives both ports; only line a is released
      wr(`XT_OFS_LINE_A, 32'h0000_0021);
      wr(`XT_OFS_LINE_B, 32'h0000_0281);
      wr(`XT_OFS_CTRL, 32'h0000_0100);
      wait_st("int_running", 2, 1'b1);
      int_cond <= 1'b1;
      wait_brk("break_req", 1'b1);
      wait_brk("break_drop", 1'b0);
      wait_st("line_a_drop", 6, 1'b0);
      chk("line_b_held", 32'h1, {31'h0, d[7]});
      chk("owner_b", 32'h1, {30'h0, d[12:11]});
      chk("bus_oe_n_held", 32'h0, {31'h0, bus_oe_n});
      chk("ports_held", 32'h0, {29'h0, bus_out_n, coax_out_n, coax_oe_n});
      wr(`XT_OFS_CTRL, 32'h0000_0400);
      int_cond <= 1'b0;
      wait_st("int_trig_halt", 4, 1'b0);
      repeat (3) @(posedge clock);
      chk("bus_oe_n_free", 32'h1, {31'h0, bus_oe_n});
      chk("ports_free", 32'h7, {29'h0, bus_out_n, coax_out_n, coax_oe_n});
      // both analyzers on one line: external triggers first
      wr(`XT_OFS_LINE_B, 32'h0);
      wr(`XT_OFS_LINE_A, 32'h0000_0005);
      wr(`XT_OFS_CTRL, 32'h0000_0200);
      wait_st("ext_running", 3, 1'b1);
      ext_cond <= 1'b1;
      wait_st("ext_trig", 5, 1'b1);
      wr(`XT_OFS_CTRL, 32'h0000_0100);
      int_cond <= 1'b1;
      wait_st("int_trig", 4, 1'b1);
      chk("owner_a", 32'h2, {30'h0, d[10:9]});
      wr(`XT_OFS_CTRL, 32'h0000_0c00);
      int_cond <= 1'b0;
      ext_cond <= 1'b0;
      // coaxial trigger arms the internal analyzer, which triggers on arm
      wr(`XT_OFS_LINE_A, 32'h0);
      wr(`XT_OFS_LINE_B, 32'h0000_0102);
      wr(`XT_OFS_CTRL, 32'h0000_0108);
      wait_st("int_unarmed", 0, 1'b0);
      repeat (3) @(posedge clock);
      chk("no_acquire", 32'h0, {31'h0, int_acquire});
      chk("no_trig", 32'h0, {31'h0, int_trig});
      pull_coax <= 1'b1;
      wait_st("int_armed", 0, 1'b1);
      pull_coax <= 1'b0;
      wait_st("trig_on_arm", 4, 1'b1);
      chk("acquire", 32'h1, {31'h0, int_acquire});
      wr(`XT_OFS_CTRL, 32'h0000_0400);
      // received bus trigger forces a break
      wr(`XT_OFS_LINE_B, 32'h0);
      wr(`XT_OFS_LINE_A, 32'h0000_0060);
      pull_bus <= 1'b1;
      wait_st("bus_break", 8, 1'b1);
      pull_bus <= 1'b0;
      wait_st("bus_break_end", 8, 1'b0);
      // execute starts the external analyzer, whose trigger arms the internal one
      wr(`XT_OFS_LINE_A, 32'h0000_0006);
      wr(`XT_OFS_CTRL, 32'h0000_0103);
      wait_st("int_wait_arm", 0, 1'b0);
      exec_req <= 1'b1;
      @(posedge clock);
      exec_req <= 1'b0;
      wait_st("exec_start", 3, 1'b1);
      ext_cond <= 1'b1;
      wait_st("cross_arm", 0, 1'b1);
      wr(`XT_OFS_CTRL, 32'h0000_0c00);
      ext_cond <= 1'b0;
      // timing mode waits for the arm before acquiring
      wr(`XT_OFS_LINE_A, 32'h0);
      wr(`XT_OFS_LINE_B, 32'h0000_0108);
      wr(`XT_OFS_CTRL, 32'h0000_0204);
      wait_st("ext_run_timing", 3, 1'b1);
      chk("timing_wait", 32'h0, {31'h0, ext_acquire});
      pull_coax <= 1'b1;
      wait_st("ext_armed", 1, 1'b1);
      pull_coax <= 1'b0;
      chk("timing_go", 32'h1, {31'h0, ext_acquire});
      conclude();
   end
endmodule
